// File: logic/radio_irq_pkg.sv
// constants for the radio interrupt aggregator
//////////////////////////////////////////////////////////////////////////////
// Contract
// - two requests go to the cpu, data transfer on vector 0, events on 12.
// - the data request rises when an rx byte is ready or a tx byte is done.
// - six radio event sources merge into one event request.
// - each event flag is set only on a low-to-high edge of its source.
// - the merged event request also drives the timer capture trigger.
// - each vector is gated by its own main enable bit.
// - each vector has a main pending flag apart from the event flags.
// - flags update from their sources whatever the mask says.
// - event vector needs both a per-source mask bit and the main enable.
// - packet-done is also set by tx underflow or rx overflow.
// - flags reset to 0, write 0 clears, write 1 keeps, bits 7:6 read 0.
// - mask holds one enable per source, resets to 0, bits 7:6 read 0.
//////////////////////////////////////////////////////////////////////////////
package radio_irq_pkg;
	localparam int unsigned n_events = 6;
	localparam logic [7:0] radio_event_mask_addr = 8'h91;
	localparam logic [7:0] radio_event_flags_addr = 8'he9;
	localparam logic [4:0] data_vector_num = 5'h00;
	localparam logic [4:0] event_vector_num = 5'h0c;
	localparam int unsigned bit_timeout = 5;
	localparam int unsigned bit_done = 4;
	localparam int unsigned bit_carrier = 3;
	localparam int unsigned bit_preamble = 2;
	localparam int unsigned bit_cca = 1;
	localparam int unsigned bit_sync = 0;
	localparam logic [5:0] flags_reset = 6'h00;
	localparam logic [5:0] mask_reset = 6'h00;
	localparam logic [7:0] unused_bits_read = 8'h00;
endpackage

// File: logic/radio_irq_aggregator.sv
// radio interrupt aggregation toward the cpu core
module radio_irq_aggregator
	import radio_irq_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port from the cpu special-register bus
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// radio status sources (levels)
	input wire logic rx_timeout_src,
	input wire logic packet_done_src,
	input wire logic tx_underflow_src,
	input wire logic rx_overflow_src,
	input wire logic carrier_sense_src,
	input wire logic preamble_quality_src,
	input wire logic clear_channel_src,
	input wire logic sync_detect_src,
	input wire logic rx_byte_ready,
	input wire logic tx_byte_done,
	// main enables from the cpu enable registers
	input wire logic data_vector_enable,
	input wire logic event_vector_enable,
	// main pending flag clears from the cpu flag registers
	input wire logic data_pending_clr,
	input wire logic event_pending_clr,
	// toward the cpu interrupt system and timer
	output logic data_vector_pending,
	output logic event_vector_pending,
	output logic data_irq,
	output logic event_irq,
	output logic [4:0] data_vector_id,
	output logic [4:0] event_vector_id,
	output logic event_request,
	output logic timer_capture_trig
);

	//////////////////////////////////////////////////////////////////////////
	// source edge detection
	logic [5:0] src_now;
	logic [5:0] src_q;
	logic [5:0] src_rise;
	logic [5:0] flags_q;
	logic [5:0] flags_d;
	logic [5:0] mask_q;
	logic [5:0] flag_clr;
	logic wr_flags;
	logic wr_mask;
	logic req_now;
	logic req_q;
	logic data_now;
	logic data_q;
	logic data_pend_q;
	logic event_pend_q;

	// done source ored with the error conditions
	assign src_now[bit_done] = packet_done_src | tx_underflow_src |
		rx_overflow_src;
	assign src_now[bit_timeout] = rx_timeout_src;
	assign src_now[bit_carrier] = carrier_sense_src;
	assign src_now[bit_preamble] = preamble_quality_src;
	assign src_now[bit_cca] = clear_channel_src;
	assign src_now[bit_sync] = sync_detect_src;
	// rising edge only, level held high never retriggers
	assign src_rise = src_now & ~src_q;

	//////////////////////////////////////////////////////////////////////////
	// register decode
	assign wr_flags = reg_wr && (reg_addr == radio_event_flags_addr);
	assign wr_mask = reg_wr && (reg_addr == radio_event_mask_addr);
	// write 0 clears, write 1
	assign flag_clr = wr_flags ? ~reg_wdata[5:0] : 6'h00;
	// set beats clear so no edge is lost; mask not consulted
	assign flags_d = src_rise | (flags_q & ~flag_clr);

	always_ff @(posedge clk) begin
		if (reset) begin
			src_q <= 6'h00;
			flags_q <= flags_reset;
			mask_q <= mask_reset;
		end else begin
			src_q <= src_now;
			flags_q <= flags_d;
			if (wr_mask) begin
				mask_q <= reg_wdata[5:0];
			end
		end
	end

	// unused top bits read as zero
	always_comb begin
		reg_rdata = unused_bits_read;
		if (reg_addr == radio_event_flags_addr) begin
			reg_rdata = {2'b00, flags_q};
		end else if (reg_addr == radio_event_mask_addr) begin
			reg_rdata = {2'b00, mask_q};
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// event vector: six sources merged, first mask layer
	assign req_now = |(flags_q & mask_q);
	// data vector source
	assign data_now = rx_byte_ready | tx_byte_done;

	// pending set on rising edge of the request, set wins over clear
	always_ff @(posedge clk) begin
		if (reset) begin
			req_q <= 1'b0;
			data_q <= 1'b0;
			data_pend_q <= 1'b0;
			event_pend_q <= 1'b0;
		end else begin
			req_q <= req_now;
			data_q <= data_now;
			data_pend_q <= (data_now & ~data_q) |
				(data_pend_q & ~data_pending_clr);
			// a held request does not re-set this; only a new rise of the request does
			event_pend_q <= (req_now & ~req_q) |
				(event_pend_q & ~event_pending_clr);
		end
	end

	assign data_vector_pending = data_pend_q;
	assign event_vector_pending = event_pend_q;
	// main enable is the second mask layer
	assign data_irq = data_pend_q & data_vector_enable;
	assign event_irq = event_pend_q & event_vector_enable;
	// fixed vector numbers
	assign data_vector_id = data_vector_num;
	assign event_vector_id = event_vector_num;
	assign event_request = req_q;
	// capture uses the merged request, independent of main enable
	assign timer_capture_trig = req_q;

	//////////////////////////////////////////////////////////////////////////
	// checks
	chk_edge_sets_flag: assert property (
		@(posedge clk) disable iff (reset)
		src_now[bit_sync] && !$past(src_now[bit_sync]) |=>
		flags_q[bit_sync])
		else $error("sync edge did not set flag");
	// right after reset the edge register is zero, so skip that cycle
	chk_no_level_set: assert property (
		@(posedge clk) disable iff (reset)
		!$past(reset) && !flags_q[bit_cca] && $past(src_now[bit_cca]) &&
		src_now[bit_cca] && !wr_flags |=> !flags_q[bit_cca])
		else $error("held level set a flag");
	chk_err_sets_done: assert property (
		@(posedge clk) disable iff (reset)
		$rose(tx_underflow_src) && !packet_done_src && !rx_overflow_src
		&& !$past(src_now[bit_done]) |=> flags_q[bit_done])
		else $error("underflow did not set done");
	chk_set_beats_clear: assert property (
		@(posedge clk) disable iff (reset)
		wr_flags && |(src_rise & flag_clr) |=>
		(flags_q & $past(src_rise)) == $past(src_rise))
		else $error("edge lost to clear");
	chk_clear_by_zero: assert property (
		@(posedge clk) disable iff (reset)
		wr_flags && reg_wdata[5:0] == 6'h00 && src_rise == 6'h00 |=>
		flags_q == 6'h00)
		else $error("write zero did not clear");
	chk_mask_no_block: assert property (
		@(posedge clk) disable iff (reset)
		src_rise[bit_timeout] && !mask_q[bit_timeout] |=>
		flags_q[bit_timeout])
		else $error("mask blocked flag update");
	chk_two_layers: assert property (
		@(posedge clk) disable iff (reset)
		event_irq |-> event_vector_enable && event_pend_q)
		else $error("event irq without enable");
	chk_pending_rise: assert property (
		@(posedge clk) disable iff (reset)
		req_now && !req_q |=> event_pend_q && event_request &&
		timer_capture_trig)
		else $error("request rise missed pending");
	chk_data_pending: assert property (
		@(posedge clk) disable iff (reset)
		$rose(data_now) |=> data_vector_pending)
		else $error("data pending not set");
	chk_rdata_top: assert property (
		@(posedge clk) disable iff (reset)
		reg_rdata[7:6] == 2'b00)
		else $error("unused bits nonzero");
	chk_flags_hold: assert property (
		@(posedge clk) disable iff (reset)
		!wr_flags && src_rise == 6'h00 |=> $stable(flags_q))
		else $error("flags changed without cause");
	chk_write_one_keeps: assert property (
		@(posedge clk) disable iff (reset)
		wr_flags && reg_wdata[5:0] == 6'h3f |=>
		(flags_q & $past(flags_q)) == $past(flags_q))
		else $error("write of ones cleared a flag");
	chk_mask_write: assert property (
		@(posedge clk) disable iff (reset)
		wr_mask |=> mask_q == $past(reg_wdata[5:0]))
		else $error("mask write not stored");
	// request register has no history in the first cycle after reset
	chk_capture_tracks: assert property (
		@(posedge clk) disable iff (reset)
		!$past(reset) |-> timer_capture_trig ==
		$past(|(flags_q & mask_q)))
		else $error("capture trigger lags request");
	chk_pend_needs_req: assert property (
		@(posedge clk) disable iff (reset)
		$rose(event_vector_pending) |-> event_request)
		else $error("pending rose without request");
	chk_vector_ids: assert property (
		@(posedge clk) disable iff (reset)
		data_vector_id == data_vector_num &&
		event_vector_id == event_vector_num)
		else $error("vector number wrong");

	cov_event_irq: cover property (@(posedge clk) disable iff (reset)
		$rose(event_irq));
	cov_data_irq: cover property (@(posedge clk) disable iff (reset)
		$rose(data_irq));
	cov_race: cover property (@(posedge clk) disable iff (reset)
		wr_flags && |(src_rise & flag_clr));
	cov_masked_flag: cover property (@(posedge clk) disable iff (reset)
		|(flags_q & ~mask_q));
	cov_capture_trig: cover property (@(posedge clk) disable iff (reset)
		$rose(timer_capture_trig));

endmodule

// File: tb/cpu_model.sv
// cpu side model: data handler clears its main pending flag
module cpu_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// handler view
	input wire logic data_irq,
	input wire logic [1:0] wait_cycles,
	output logic data_pending_clr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_q;
	// slow handler: clear only after wait_cycles of latency
	always_ff @(posedge clk) begin
		if (reset || !data_irq) begin
			cnt_q <= 2'h0;
			data_pending_clr <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 2'h1;
			data_pending_clr <= (cnt_q == wait_cycles);
		end
	end
endmodule

// File: tb/testbench.sv
// self-checking bench for the radio interrupt aggregator
module testbench
	import radio_irq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset = 1, reg_wr = 0, rxr = 0, txd = 0;
	logic den = 1, een = 1, eclr = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, src = 8'h00;
	logic [31:0] seed = 32'h55;
	wire [7:0] rdata;
	wire dclr, dpend, epend, dirq, eirq, ereq, trig;
	wire [4:0] did, eid;
	int errors = 0, check_count = 0, i;
	////////////////////////////////////////
	radio_irq_aggregator dut (.clk(clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(rdata), .rx_timeout_src(src[5]),
		.packet_done_src(src[4]), .tx_underflow_src(src[6]),
		.rx_overflow_src(src[7]), .carrier_sense_src(src[3]),
		.preamble_quality_src(src[2]), .clear_channel_src(src[1]),
		.sync_detect_src(src[0]), .rx_byte_ready(rxr), .tx_byte_done(txd),
		.data_vector_enable(den), .event_vector_enable(een),
		.data_pending_clr(dclr), .event_pending_clr(eclr),
		.data_vector_pending(dpend), .event_vector_pending(epend),
		.data_irq(dirq), .event_irq(eirq), .data_vector_id(did),
		.event_vector_id(eid), .event_request(ereq),
		.timer_capture_trig(trig));
	// slowest handler, so pending is seen before it is cleared
	cpu_model cpu (.clk(clk), .reset(reset), .data_irq(dirq),
		.wait_cycles(2'h3), .data_pending_clr(dclr));
	////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		reg_addr <= a;
		@(posedge clk);
		#1 chk(rdata, exp);
		@(posedge clk);
	endtask
	// overflow and underflow both land on the done flag
	function automatic logic [7:0] fexp(input int k);
		return (k < 6) ? 8'h01 << k : 8'h10;
	endfunction
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic finish_test;
		if (errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial forever #10 clk = ~clk;
	initial begin
		#50000;
		errors++;
		finish_test();
	end
	initial begin
		tick(2);
		reset <= 1'b0;
		rd(radio_event_flags_addr, 8'h00);
		rd(radio_event_mask_addr, 8'h00);
		chk({3'h0, did}, 8'h00);
		chk({3'h0, eid}, 8'h0c);
		for (i = 0; i < 8; i++) begin
			src <= 8'h01 << i;
			tick(3);
			rd(radio_event_flags_addr, fexp(i));
			wr(radio_event_flags_addr, 8'hff);
			rd(radio_event_flags_addr, fexp(i));
			wr(radio_event_flags_addr, 8'h00);
			rd(radio_event_flags_addr, 8'h00);
			src <= 8'h00;
			tick(1);
		end
		tick(1);
		src <= 8'h08;
		wr(radio_event_flags_addr, 8'h00);
		rd(radio_event_flags_addr, 8'h08);
		#1 chk({7'h0, ereq}, 8'h00);
		tick(1);
		wr(radio_event_mask_addr, 8'h08);
		tick(2);
		#1 chk({6'h0, ereq, trig}, 8'h03);
		chk({6'h0, epend, eirq}, 8'h03);
		tick(1);
		een <= 1'b0;
		tick(1);
		#1 chk({6'h0, epend, eirq}, 8'h02);
		tick(1);
		wr(radio_event_flags_addr, 8'h00);
		eclr <= 1'b1;
		tick(1);
		eclr <= 1'b0;
		tick(3);
		#1 chk({6'h0, ereq, epend}, 8'h00);
		tick(1);
		een <= 1'b1;
		rxr <= 1'b1;
		tick(2);
		#1 chk({6'h0, dpend, dirq}, 8'h03);
		tick(6);
		#1 chk({7'h0, dpend}, 8'h00);
		tick(1);
		rxr <= 1'b0;
		den <= 1'b0;
		tick(2);
		txd <= 1'b1;
		tick(2);
		#1 chk({6'h0, dpend, dirq}, 8'h02);
		tick(1);
		for (i = 0; i < 8; i++) begin
			seed = xs(seed);
			wr(radio_event_mask_addr, seed[7:0]);
			rd(radio_event_mask_addr, seed[7:0] & 8'h3f);
		end
		// flags under a random mask, then a reset in mid-run
		src <= 8'h21;
		txd <= 1'b0;
		tick(2);
		rd(radio_event_flags_addr, 8'h21);
		src <= 8'h00;
		reset <= 1'b1;
		tick(2);
		reset <= 1'b0;
		rd(radio_event_flags_addr, 8'h00);
		rd(radio_event_mask_addr, 8'h00);
		#1 chk({6'h0, dpend, epend}, 8'h00);
		finish_test();
	end
endmodule
